// *** design/global_event_flags.sv ***
// Two read-to-clear global event-flag registers and the interrupt drive.
// Each source is synchronised, turned into edge pulses and latched into a
// sticky flag; a read of a register returns its flags and clears them.
// Assumes detector outputs and pins are asynchronous levels; the read port,
// masks and pin directions come from same-clock logic.
`timescale 1ns/1ns
`default_nettype none
module global_event_flags (
  // Clock and synchronous active-low reset
  input wire logic clk,
  input wire logic rst_n,
  // Detector levels and pins, all asynchronous to clk
  input wire logic dropout_detect,
  input wire logic thermal_threshold_one,
  input wire logic thermal_threshold_two,
  input wire logic enable_pin_active_low,
  input wire logic [1:0] general_input_pin,
  // Same-clock pin direction (1 = input) and masks (1 = masked); the two regulator levels are asynchronous lanes
  input wire logic [1:0] pin_is_input,
  input wire logic linear_regulator_fault,
  input wire logic switching_regulator_timeout,
  input wire logic [7:0] mask_a,
  input wire logic [7:0] mask_b,
  // Read port from the serial bus slave
  input wire logic rd_strobe,
  input wire logic [7:0] rd_addr,
  output logic [7:0] rd_data,
  output logic rd_valid,
  // Pin drive, low while an unmasked flag is pending
  output logic interrupt_output_active_low
);
  // Synchroniser lanes, their raw edges and the qualified edges
  logic [event_flag_pkg::LANES-1:0] lane_in;
  logic [event_flag_pkg::LANES-1:0] lane_rise;
  logic [event_flag_pkg::LANES-1:0] lane_fall;
  logic [event_flag_pkg::LANES-1:0] raw_rise;
  logic [event_flag_pkg::LANES-1:0] raw_fall;
  logic [2:0] warm_up;
  logic armed;
  // Flag state, event pulses and next values
  logic [7:0] global_event_flags_a;
  logic [7:0] global_event_flags_b;
  logic [7:0] set_a;
  logic [7:0] set_b;
  logic [7:0] next_flags_a;
  logic [7:0] next_flags_b;
  // Read clears and unmasked drive
  logic clear_a;
  logic clear_b;
  logic pending_a;
  logic pending_b;
  logic pending;

  // Address decode, shared by the clear strobes and the read mux
  function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] off);
    addr_hit = (a == off);
  endfunction

  // Sticky update: a set in the clearing cycle survives the clear, and
  // bits outside the used mask can never latch
  function automatic logic [7:0] sticky_next(
    input logic [7:0] held,
    input logic [7:0] evt,
    input logic clear,
    input logic [7:0] used
  );
    sticky_next = ((clear ? 8'h00 : held) | evt) & used;
  endfunction

  // Status word: only the gate-drive mirror is kept, the rest reads zero
  function automatic logic [7:0] status_word(input logic drive);
    status_word = event_flag_pkg::READ_ZERO;
    status_word[event_flag_pkg::STATUS_IRQ_BIT] = drive;
  endfunction

  // One lane per asynchronous source, in the order fixed by the package
  assign lane_in[event_flag_pkg::LANE_DROPOUT] = dropout_detect;
  assign lane_in[event_flag_pkg::LANE_THERMAL_ONE] = thermal_threshold_one;
  assign lane_in[event_flag_pkg::LANE_THERMAL_TWO] = thermal_threshold_two;
  assign lane_in[event_flag_pkg::LANE_ENABLE] = enable_pin_active_low;
  assign lane_in[event_flag_pkg::LANE_PIN0] = general_input_pin[0];
  assign lane_in[event_flag_pkg::LANE_PIN1] = general_input_pin[1];
  assign lane_in[event_flag_pkg::LANE_LINEAR] = linear_regulator_fault;
  assign lane_in[event_flag_pkg::LANE_SWITCHING] = switching_regulator_timeout;

  // Every external level is synchronised before its edges are used
  genvar g;
  generate
    for (g = 0; g < event_flag_pkg::LANES; g = g + 1) begin : g_lane
      sync_edge u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .async_in(lane_in[g]),
        .rise(raw_rise[g]),
        .fall(raw_fall[g])
      );
    end
  endgenerate

  // Warm-up: every synchroniser chain resets low, so a level that is
  // already high at release (the enable pin idles high) would look like a
  // rising edge two cycles later. Edges are ignored until the chain and its
  // history flop both hold real samples; a level that is already there at
  // the first edge after release is the starting level, not an event.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      warm_up <= 3'h0;
    end else begin
      warm_up <= {warm_up[1:0], 1'b1};
    end
  end

  assign armed = warm_up[2];

  // Qualified edge pulses, as used by the flag logic
  assign lane_rise = raw_rise & {event_flag_pkg::LANES{armed}};
  assign lane_fall = raw_fall & {event_flag_pkg::LANES{armed}};

  // Event pulses into the first register
  always_comb begin
    set_a = 8'h00;
    set_a[event_flag_pkg::DROPOUT_RISE_BIT] =
      lane_rise[event_flag_pkg::LANE_DROPOUT];
    set_a[event_flag_pkg::THERMAL_TWO_RISE_BIT] =
      lane_rise[event_flag_pkg::LANE_THERMAL_TWO];
    set_a[event_flag_pkg::THERMAL_ONE_RISE_BIT] =
      lane_rise[event_flag_pkg::LANE_THERMAL_ONE];
    set_a[event_flag_pkg::ENABLE_RISE_BIT] =
      lane_rise[event_flag_pkg::LANE_ENABLE];
    set_a[event_flag_pkg::ENABLE_FALL_BIT] =
      lane_fall[event_flag_pkg::LANE_ENABLE];
    // A pin driven as an output gives no edges
    set_a[event_flag_pkg::PIN0_RISE_BIT] =
      lane_rise[event_flag_pkg::LANE_PIN0] & pin_is_input[0];
    set_a[event_flag_pkg::PIN0_FALL_BIT] =
      lane_fall[event_flag_pkg::LANE_PIN0] & pin_is_input[0];
  end

  // Event pulses into the second register
  always_comb begin
    set_b = 8'h00;
    set_b[event_flag_pkg::LINEAR_FAULT_BIT] =
      lane_rise[event_flag_pkg::LANE_LINEAR];
    set_b[event_flag_pkg::SWITCHING_TIMEOUT_BIT] =
      lane_rise[event_flag_pkg::LANE_SWITCHING];
    set_b[event_flag_pkg::PIN1_RISE_BIT] =
      lane_rise[event_flag_pkg::LANE_PIN1] & pin_is_input[1];
    set_b[event_flag_pkg::PIN1_FALL_BIT] =
      lane_fall[event_flag_pkg::LANE_PIN1] & pin_is_input[1];
  end

  // A read clears its register at the same edge that samples it
  assign clear_a = rd_strobe & addr_hit(rd_addr, event_flag_pkg::FLAGS_A_OFFSET);
  assign clear_b = rd_strobe & addr_hit(rd_addr, event_flag_pkg::FLAGS_B_OFFSET);

  // Next flag values; unused bits are forced to zero so they can never latch
  assign next_flags_a = sticky_next(global_event_flags_a, set_a, clear_a,
    event_flag_pkg::FLAGS_A_USED);
  assign next_flags_b = sticky_next(global_event_flags_b, set_b, clear_b,
    event_flag_pkg::FLAGS_B_USED);

  // First flag register, held until the host reads it
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      global_event_flags_a <= event_flag_pkg::FLAGS_RESET;
    end else begin
      global_event_flags_a <= next_flags_a;
    end
  end

  // Second flag register, same treatment
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      global_event_flags_b <= event_flag_pkg::FLAGS_RESET;
    end else begin
      global_event_flags_b <= next_flags_b;
    end
  end

  // Unmasked gate drive: any set flag whose mask bit is clear; each mask
  // only gates the flags of its own register
  assign pending_a = |(global_event_flags_a & ~mask_a);
  assign pending_b = |(global_event_flags_b & ~mask_b);
  assign pending = pending_a | pending_b;

  // Registered pin drive, one cycle behind the flags
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      interrupt_output_active_low <= 1'b1;
    end else begin
      interrupt_output_active_low <= ~pending;
    end
  end

  // Answer strobe, raised at the edge that takes the request, for one cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= rd_strobe;
    end
  end

  // Read data returns the value held before the clear takes effect, and
  // then stands until the next read so a slow host can still pick it up
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_data <= event_flag_pkg::READ_ZERO;
    end else begin
      if (!rd_strobe) begin
        rd_data <= rd_data;
      end else if (clear_a) begin
        rd_data <= global_event_flags_a;
      end else if (clear_b) begin
        rd_data <= global_event_flags_b;
      end else if (addr_hit(rd_addr, event_flag_pkg::STATUS_OFFSET)) begin
        rd_data <= status_word(pending);
      end else begin
        rd_data <= event_flag_pkg::READ_ZERO; // Unmapped addresses read zero
      end
    end
  end
endmodule
`default_nettype wire

// *** common/event_flag_pkg.sv ***
// Constants for the two global event-flag registers and their read port.
// Assumes a same-clock register read port driven by the serial bus slave.
// What this block does
// - Flags stick until read; read clears register
// - First register bit 7: dropout entered
// - Unused bits meaningless; write zero, ignore reads
// - First register bit 5: above threshold two
// - First register bit 4: above threshold one
// - First register bit 3: enable pin rises
// - First register bit 2: enable pin falls
// - First register bit 1: input pin0 rises
// - First register bit 0: input pin0 falls
// - Pin edges count only while pin is input
// - Second register bit 5: linear regulator fault
// - Second register bit 4: switching regulator timeout
// - Second register bit 1: input pin1 rises
// - Second register bit 0: input pin1 falls
// - Status bit 0 mirrors unmasked interrupt drive
package event_flag_pkg;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] FLAGS_A_OFFSET = 8'h00;
  localparam logic [7:0] FLAGS_B_OFFSET = 8'h04;
  localparam logic [7:0] STATUS_OFFSET = 8'h06;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [7:0] READ_ZERO = 8'h00;
  // Bits that hold a flag; the rest always read zero
  localparam logic [7:0] FLAGS_A_USED = 8'hbf;
  localparam logic [7:0] FLAGS_B_USED = 8'h33;
  // Field positions, first register
  localparam int unsigned DROPOUT_RISE_BIT = 7;
  localparam int unsigned THERMAL_TWO_RISE_BIT = 5;
  localparam int unsigned THERMAL_ONE_RISE_BIT = 4;
  localparam int unsigned ENABLE_RISE_BIT = 3;
  localparam int unsigned ENABLE_FALL_BIT = 2;
  localparam int unsigned PIN0_RISE_BIT = 1;
  localparam int unsigned PIN0_FALL_BIT = 0;
  // Field positions, second register
  localparam int unsigned LINEAR_FAULT_BIT = 5;
  localparam int unsigned SWITCHING_TIMEOUT_BIT = 4;
  localparam int unsigned PIN1_RISE_BIT = 1;
  localparam int unsigned PIN1_FALL_BIT = 0;
  // Status register field
  localparam int unsigned STATUS_IRQ_BIT = 0;
  // Synchronised input lanes
  localparam int unsigned LANE_DROPOUT = 0;
  localparam int unsigned LANE_THERMAL_ONE = 1;
  localparam int unsigned LANE_THERMAL_TWO = 2;
  localparam int unsigned LANE_ENABLE = 3;
  localparam int unsigned LANE_PIN0 = 4;
  localparam int unsigned LANE_PIN1 = 5;
  localparam int unsigned LANE_LINEAR = 6;
  localparam int unsigned LANE_SWITCHING = 7;
  localparam int unsigned LANES = 8;
endpackage

// *** design/sync_edge.sv ***
// Two-flop synchroniser for one asynchronous level, with edge pulses.
// Assumes the input is a level from outside the clock domain.
`timescale 1ns/1ns
`default_nettype none
module sync_edge (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic async_in,
  output logic rise,
  output logic fall
);
  logic meta;
  logic stable;
  logic prev;

  // First flop feeds only the second; edges are seen on the stable copies
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta <= 1'b0;
      stable <= 1'b0;
      prev <= 1'b0;
    end else begin
      meta <= async_in;
      stable <= meta;
      prev <= stable;
    end
  end

  // One-cycle pulses per transition
  assign rise = stable & ~prev;
  assign fall = ~stable & prev;
endmodule
`default_nettype wire

// *** bench/global_event_flags_chk.sv ***
// Checker for the global event-flag block: read port and interrupt relations.
// Sees only the top ports; bound to every instance of the block.
`timescale 1ns/1ns
`default_nettype none
module global_event_flags_chk (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] mask_a,
  input wire logic [7:0] mask_b,
  input wire logic rd_strobe,
  input wire logic [7:0] rd_addr,
  input wire logic [7:0] rd_data,
  input wire logic rd_valid,
  input wire logic interrupt_output_active_low
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // Read answers come exactly one cycle after the request
  a_valid_follows: assert property (rd_strobe |=> rd_valid)
    else $error("read not answered");
  a_valid_cause: assert property (rd_valid |-> $past(rd_strobe))
    else $error("answer without request");
  // Returned data holds between reads so the host can sample late
  a_data_holds: assert property (!rd_valid |-> $stable(rd_data))
    else $error("read data moved");
  // Unused flag bits never read back as set
  a_spare_a_zero: assert property (
    rd_valid && $past(rd_addr) == 8'h00 |-> !rd_data[6])
    else $error("spare bit in first register");
  a_spare_b_zero: assert property (
    rd_valid && $past(rd_addr) == 8'h04 |-> rd_data[7:6] == 2'b00 && rd_data[3:2] == 2'b00)
    else $error("spare bit in second register");
  a_other_zero: assert property (
    rd_valid && !($past(rd_addr) inside {8'h00, 8'h04, 8'h06}) |-> rd_data == 8'h00)
    else $error("unmapped read not zero");
  // Status bit matches the registered pin, both taken from one pending value
  a_status_mirror: assert property (
    rd_valid && $past(rd_addr) == 8'h06 |-> rd_data == {7'h00, !interrupt_output_active_low})
    else $error("status bit disagrees with pin");
  a_masked_quiet: assert property (
    (&{mask_a, mask_b}) [*2] |-> interrupt_output_active_low)
    else $error("pin low with all masked");
  c_flag_read: cover property (rd_valid && $past(rd_addr) == 8'h00 && rd_data != 8'h00);
  c_irq_low: cover property (!interrupt_output_active_low);
  c_status_set: cover property (rd_valid && $past(rd_addr) == 8'h06 && rd_data[0]);
endmodule
bind global_event_flags global_event_flags_chk chk_u (.clk(clk), .rst_n(rst_n),
  .mask_a(mask_a), .mask_b(mask_b), .rd_strobe(rd_strobe), .rd_addr(rd_addr),
  .rd_data(rd_data), .rd_valid(rd_valid),
  .interrupt_output_active_low(interrupt_output_active_low));
`default_nettype wire

// *** bench/flag_host.sv ***
// Host model for the flag read port: issues reads, collects answers.
// Assumes the block answers at the taking edge, one cycle after the request.
`timescale 1ns/1ns
`default_nettype none
module flag_host (
  input wire logic clk,
  input wire logic rd_valid,
  input wire logic [7:0] rd_data,
  output logic rd_strobe,
  output logic [7:0] rd_addr
);
  initial begin
    rd_strobe = 1'b0;
    rd_addr = 8'h00;
  end
  // Spare bits are never written: there is no write path here
  // Released address shows its inverse so a stale value is never reused.
  // The answer stands for one cycle after the taking edge, so it is taken
  // just after that edge; the idle cycle that follows keeps back-to-back
  // calls from touching the strobe twice in one time step.
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    rd_strobe = 1'b1;
    rd_addr = a;
    @(posedge clk);
    #1;
    d = (rd_valid === 1'b1) ? rd_data : 8'hxx;
    rd_strobe = 1'b0;
    rd_addr = ~a;
    @(posedge clk);
    #1;
  endtask
endmodule
`default_nettype wire

// *** bench/tb_global_event_flags.sv ***
// Self-checking bench for the global event-flag block.
// Assumes the host model owns the read port; event levels start low.
`timescale 1ns/1ns
`default_nettype none
module tb_global_event_flags;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] lane = 8'h00;
  logic [1:0] pin_is_input = 2'b11;
  logic [7:0] mask_a = 8'h00;
  logic [7:0] mask_b = 8'h00;
  logic rd_strobe, rd_valid, irq;
  logic [7:0] rd_addr, rd_data, d;
  int miscompares = 0;
  int n_checks = 0;
  int cycles = 0;
  // Expected flags per lane: rise then fall, first and second register
  logic [7:0] rise_a [8] = '{8'h80, 8'h10, 8'h20, 8'h08, 8'h02, 8'h00, 8'h00, 8'h00};
  logic [7:0] rise_b [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h20, 8'h10};
  logic [7:0] fall_a [8] = '{8'h00, 8'h00, 8'h00, 8'h04, 8'h01, 8'h00, 8'h00, 8'h00};
  logic [7:0] fall_b [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00};
  always #25 clk = ~clk;
  global_event_flags dut_u (.clk(clk), .rst_n(rst_n), .dropout_detect(lane[0]),
    .thermal_threshold_one(lane[1]), .thermal_threshold_two(lane[2]),
    .enable_pin_active_low(lane[3]), .general_input_pin(lane[5:4]),
    .pin_is_input(pin_is_input), .linear_regulator_fault(lane[6]),
    .switching_regulator_timeout(lane[7]), .mask_a(mask_a), .mask_b(mask_b),
    .rd_strobe(rd_strobe), .rd_addr(rd_addr), .rd_data(rd_data), .rd_valid(rd_valid),
    .interrupt_output_active_low(irq));
  flag_host host_u (.clk(clk), .rd_valid(rd_valid), .rd_data(rd_data),
    .rd_strobe(rd_strobe), .rd_addr(rd_addr));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic stop_test();
    $display("checks=%0d miscompares=%0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Hang guard, far above the 247 cycles the tests need
  always @(posedge clk) begin
    cycles++;
    if (cycles == 1000) begin
      miscompares++;
      stop_test();
    end
  end
  initial begin
    tick(10);
    rst_n = 1'b1;
    tick(3);
    host_u.read_reg(8'h00, d);
    check(d, 8'h00);
    host_u.read_reg(8'h04, d);
    check(d, 8'h00);
    host_u.read_reg(8'h01, d);
    check(d, 8'h00);
    $display("reset test done");
    for (int i = 0; i < 8; i++) begin
      lane[i] = 1'b1;
      tick(5);
      check({7'h00, irq}, 8'h00);
      host_u.read_reg(8'h00, d);
      check(d, rise_a[i]);
      host_u.read_reg(8'h04, d);
      check(d, rise_b[i]);
      lane[i] = 1'b0;
      tick(5);
      host_u.read_reg(8'h00, d);
      check(d, fall_a[i]);
      host_u.read_reg(8'h04, d);
      check(d, fall_b[i]);
      tick(2);
      check({7'h00, irq}, 8'h01);
    end
    $display("event test done");
    pin_is_input = 2'b00;
    tick(2);
    lane[5:4] = 2'b11;
    tick(5);
    lane[5:4] = 2'b00;
    tick(5);
    pin_is_input = 2'b11;
    host_u.read_reg(8'h00, d);
    check(d, 8'h00);
    host_u.read_reg(8'h04, d);
    check(d, 8'h00);
    $display("direction test done");
    mask_a = 8'hff;
    mask_b = 8'hff;
    lane[0] = 1'b1;
    tick(6);
    check({7'h00, irq}, 8'h01);
    host_u.read_reg(8'h06, d);
    check(d, 8'h00);
    mask_a = 8'h7f;
    tick(3);
    check({7'h00, irq}, 8'h00);
    host_u.read_reg(8'h06, d);
    check(d, 8'h01);
    host_u.read_reg(8'h00, d);
    check(d, 8'h80);
    host_u.read_reg(8'h00, d);
    check(d, 8'h00);
    check({7'h00, irq}, 8'h01);
    $display("mask test done");
    // Dropout edge lands in the very cycle its register is read and cleared
    lane[0] = 1'b0;
    tick(5);
    lane[0] = 1'b1;
    tick(2);
    host_u.read_reg(8'h00, d);
    check(d, 8'h00);
    host_u.read_reg(8'h00, d);
    check(d, 8'h80);
    $display("set wins test done");
    // Levels already high through a mid-run reset are no edges
    lane[3] = 1'b1;
    rst_n = 1'b0;
    tick(10);
    rst_n = 1'b1;
    tick(5);
    host_u.read_reg(8'h00, d);
    check(d, 8'h00);
    check({7'h00, irq}, 8'h01);
    lane[3] = 1'b0;
    tick(5);
    host_u.read_reg(8'h00, d);
    check(d, 8'h04);
    $display("second reset test done");
    stop_test();
  end
endmodule
`default_nettype wire
